// >>> logic/sbdl_link.sv
// Functional notes
// - Fields move MSB first, nominal 16 debug clocks per bit.
// - 512 debug clocks without a host falling edge abort the command.
// - Clock select chooses bus clock or alternate source for all timing but the start-mode settle.
// - Bit start seen after the edge; pin sampled ten debug clocks later.
// - Target leaves the pin undriven while the host sends a bit.
// - Returned one is a high speedup pulse seven clocks after start.
// - Returned zero is low for 13 clocks, then a brief high pulse.
// - Pin low at reset release selects active background start.
// - Link works without a reset, even while the program runs.
// - Active background commands only in that mode; others always.
// - Rate-probe request answered with a timed response pulse.
// - After pin high, wait 16, drive low 128, pulse one, release.
// - Delay slot lasts 16 debug clocks before the host continues.
`timescale 1ns/10ps
`default_nettype none
module sbdl_link #(
  parameter int TX_W = 16,
  parameter int RX_W = 8
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Debug serial pin
  input wire logic debug_serial_pin_i,
  output logic debug_serial_pin_o,
  output logic debug_serial_pin_oe_n_o,
  // Debug clock selection
  input wire logic debug_clock_select_i,
  input wire logic alt_clk_tick_i,
  // Bits returned to the host
  input wire logic tx_load_i,
  input wire logic [TX_W-1:0] tx_data_i,
  input wire logic [4:0] tx_bits_i,
  output logic tx_busy_o,
  // Bits received from the host
  output logic [RX_W-1:0] rx_data_o,
  output logic rx_valid_o,
  // Command class, delay slot, timeout
  input wire logic bgnd_mode_i,
  input wire logic cmd_active_class_i,
  output logic cmd_allowed_o,
  input wire logic delay_req_i,
  output logic delay_done_o,
  output logic timeout_o,
  // Start mode caught after reset, rate-probe response busy
  output logic bgnd_start_o,
  output logic sync_busy_o
);
  if (TX_W < 1 || TX_W > 16 || RX_W < 2 || RX_W > 16)
  begin : g_chk
    $error("sbdl_link: TX_W must be 1..16 and RX_W 2..16");
  end

  // Short local names for the package state codes
  localparam sbdl_pkg::sbdl_state_e ST_IDLE = sbdl_pkg::ST_IDLE;
  localparam sbdl_pkg::sbdl_state_e ST_BIT = sbdl_pkg::ST_BIT;
  localparam sbdl_pkg::sbdl_state_e ST_SY_HIGH = sbdl_pkg::ST_SY_HIGH;
  localparam sbdl_pkg::sbdl_state_e ST_SY_DLY = sbdl_pkg::ST_SY_DLY;
  localparam sbdl_pkg::sbdl_state_e ST_SY_LOW = sbdl_pkg::ST_SY_LOW;
  localparam sbdl_pkg::sbdl_state_e ST_SY_PULSE = sbdl_pkg::ST_SY_PULSE;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sbdl_pin_if pin ();
  sbdl_pin_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .pin(pin.sync)
  );
  assign pin.pin_raw = debug_serial_pin_i;

  // ==========================================================
  // State
  sbdl_pkg::sbdl_state_e state_reg, state_next;
  logic [sbdl_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [sbdl_pkg::CNT_W-1:0] low_reg, low_next;
  logic [sbdl_pkg::TO_W-1:0] to_reg, to_next;
  logic [sbdl_pkg::DLY_W-1:0] dly_reg, dly_next;
  logic [sbdl_pkg::BOOT_W-1:0] boot_reg, boot_next;
  logic [TX_W-1:0] tx_sh_reg, tx_sh_next;
  logic [4:0] tx_left_reg, tx_left_next;
  logic [RX_W-1:0] rx_sh_reg, rx_sh_next, rx_data_reg, rx_data_next;
  logic [4:0] rx_cnt_reg, rx_cnt_next;
  logic cur_tx_reg, cur_tx_next, cur_bit_reg, cur_bit_next;
  logic drv_reg, drv_next, lvl_reg, lvl_next;
  logic rx_valid_reg, rx_valid_next, to_pulse_reg, to_pulse_next;
  logic done_reg, done_next, bgnd_reg, bgnd_next;
  logic tick;
  logic [sbdl_pkg::CNT_W-1:0] cnt_inc;

  // Bus clock ticks every cycle; the alternate source arrives as an enable
  assign tick = debug_clock_select_i ? alt_clk_tick_i : 1'b1;
  assign cnt_inc = cnt_reg + 1'b1;

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    low_next = low_reg;
    to_next = to_reg;
    dly_next = dly_reg;
    boot_next = boot_reg;
    tx_sh_next = tx_sh_reg;
    tx_left_next = tx_left_reg;
    rx_sh_next = rx_sh_reg;
    rx_data_next = rx_data_reg;
    rx_cnt_next = rx_cnt_reg;
    cur_tx_next = cur_tx_reg;
    cur_bit_next = cur_bit_reg;
    drv_next = drv_reg;
    lvl_next = lvl_reg;
    rx_valid_next = 1'b0;
    to_pulse_next = 1'b0;
    done_next = 1'b0;
    bgnd_next = bgnd_reg;

    // Start mode is caught once the synchroniser has settled
    if (boot_reg != sbdl_pkg::BOOT_W'(sbdl_pkg::BOOT_SETTLE_CYC))
    begin
      boot_next = boot_reg + 1'b1;
      if (boot_reg == sbdl_pkg::BOOT_W'(sbdl_pkg::BOOT_SETTLE_CYC - 1))
        bgnd_next = ~pin.pin_sync;
    end

    if (tx_load_i && tx_left_reg == 5'h00)
    begin
      tx_sh_next = tx_data_i;
      tx_left_next = tx_bits_i;
    end

    if (delay_req_i)
      dly_next = sbdl_pkg::DLY_W'(sbdl_pkg::DELAY_CYC);
    else if (tick && dly_reg != '0)
    begin
      dly_next = dly_reg - 1'b1;
      done_next = (dly_reg == sbdl_pkg::DLY_W'(1));
    end

    // Long host low, never our own drive, marks a rate-probe request
    if (!pin.pin_sync && !drv_reg)
    begin
      if (tick && low_reg != sbdl_pkg::CNT_W'(sbdl_pkg::SYNC_DET_CYC))
        low_next = low_reg + 1'b1;
    end
    else
      low_next = '0;

    case (state_reg)
      ST_IDLE:
      begin
        drv_next = 1'b0;
        lvl_next = 1'b0;
        if (pin.pin_fall)
        begin
          state_next = ST_BIT;
          cnt_next = '0;
          cur_tx_next = (tx_left_reg != 5'h00);
          cur_bit_next = tx_sh_reg[TX_W-1];
          if (tx_left_reg != 5'h00 && !tx_sh_reg[TX_W-1])
            drv_next = 1'b1;
        end
      end
      ST_BIT:
      begin
        if (tick)
        begin
          cnt_next = cnt_inc;
          if (cur_tx_reg && !cur_bit_reg)
          begin
            drv_next = (cnt_inc <= sbdl_pkg::CNT_W'(sbdl_pkg::ZERO_LOW_CYC));
            lvl_next = (cnt_inc == sbdl_pkg::CNT_W'(sbdl_pkg::ZERO_LOW_CYC));
          end
          else if (cur_tx_reg)
          begin
            drv_next = (cnt_inc == sbdl_pkg::CNT_W'(sbdl_pkg::ONE_PULSE_CYC));
            lvl_next = drv_next;
          end
          else if (cnt_inc == sbdl_pkg::CNT_W'(sbdl_pkg::SAMPLE_CYC))
          begin
            rx_sh_next = {rx_sh_reg[RX_W-2:0], pin.pin_sync};
            rx_cnt_next = rx_cnt_reg + 1'b1;
            if (rx_cnt_reg == 5'(RX_W - 1))
            begin
              rx_data_next = {rx_sh_reg[RX_W-2:0], pin.pin_sync};
              rx_valid_next = 1'b1;
              rx_cnt_next = '0;
            end
          end
          if (cnt_inc == sbdl_pkg::CNT_W'(sbdl_pkg::BIT_CYC - 1))
          begin
            state_next = ST_IDLE;
            if (cur_tx_reg)
            begin
              tx_sh_next = tx_sh_reg << 1;
              tx_left_next = tx_left_reg - 1'b1;
            end
          end
        end
      end
      ST_SY_HIGH:
      begin
        if (pin.pin_sync)
        begin
          state_next = ST_SY_DLY;
          cnt_next = '0;
        end
      end
      ST_SY_DLY:
      begin
        if (tick)
        begin
          cnt_next = cnt_inc;
          if (cnt_inc == sbdl_pkg::CNT_W'(sbdl_pkg::SYNC_WAIT_CYC))
          begin
            state_next = ST_SY_LOW;
            cnt_next = '0;
            drv_next = 1'b1;
            lvl_next = 1'b0;
          end
        end
      end
      ST_SY_LOW:
      begin
        if (tick)
        begin
          cnt_next = cnt_inc;
          if (cnt_inc == sbdl_pkg::CNT_W'(sbdl_pkg::SYNC_LOW_CYC))
          begin
            state_next = ST_SY_PULSE;
            lvl_next = 1'b1;
          end
        end
      end
      ST_SY_PULSE:
      begin
        if (tick)
        begin
          state_next = ST_IDLE;
          drv_next = 1'b0;
          lvl_next = 1'b0;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
        drv_next = 1'b0;
      end
    endcase

    if ((state_reg == ST_IDLE || state_reg == ST_BIT) &&
        low_next == sbdl_pkg::CNT_W'(sbdl_pkg::SYNC_DET_CYC))
    begin
      state_next = ST_SY_HIGH;
      drv_next = 1'b0;
      rx_cnt_next = '0;
    end

    // A timeout drops the half-done field but leaves a sync response running
    if (pin.pin_fall)
      to_next = '0;
    else if (tick && to_reg != sbdl_pkg::TO_W'(sbdl_pkg::TIMEOUT_CYC))
    begin
      to_next = to_reg + 1'b1;
      if (to_reg == sbdl_pkg::TO_W'(sbdl_pkg::TIMEOUT_CYC - 1))
      begin
        to_pulse_next = 1'b1;
        tx_left_next = '0;
        rx_cnt_next = '0;
        dly_next = '0;
        if (state_reg == ST_BIT)
        begin
          state_next = ST_IDLE;
          drv_next = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      low_reg <= '0;
      to_reg <= '0;
      dly_reg <= '0;
      boot_reg <= '0;
      tx_sh_reg <= '0;
      tx_left_reg <= '0;
      rx_sh_reg <= '0;
      rx_data_reg <= '0;
      rx_cnt_reg <= '0;
      cur_tx_reg <= 1'b0;
      cur_bit_reg <= 1'b0;
      drv_reg <= 1'b0;
      lvl_reg <= 1'b0;
      rx_valid_reg <= 1'b0;
      to_pulse_reg <= 1'b0;
      done_reg <= 1'b0;
      bgnd_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      low_reg <= low_next;
      to_reg <= to_next;
      dly_reg <= dly_next;
      boot_reg <= boot_next;
      tx_sh_reg <= tx_sh_next;
      tx_left_reg <= tx_left_next;
      rx_sh_reg <= rx_sh_next;
      rx_data_reg <= rx_data_next;
      rx_cnt_reg <= rx_cnt_next;
      cur_tx_reg <= cur_tx_next;
      cur_bit_reg <= cur_bit_next;
      drv_reg <= drv_next;
      lvl_reg <= lvl_next;
      rx_valid_reg <= rx_valid_next;
      to_pulse_reg <= to_pulse_next;
      done_reg <= done_next;
      bgnd_reg <= bgnd_next;
    end
  end

  // ==========================================================
  // Outputs
  assign debug_serial_pin_o = lvl_reg;
  assign debug_serial_pin_oe_n_o = ~drv_reg;
  assign tx_busy_o = (tx_left_reg != 5'h00);
  assign rx_data_o = rx_data_reg;
  assign rx_valid_o = rx_valid_reg;
  assign timeout_o = to_pulse_reg;
  assign delay_done_o = done_reg;
  assign bgnd_start_o = bgnd_reg;
  assign sync_busy_o = (state_reg >= ST_SY_HIGH);
  assign cmd_allowed_o = !cmd_active_class_i || bgnd_mode_i;

  // ==========================================================
  // Assertions
  // A speedup pulse is one high drive phase, then a clean release
  sequence s_release;
    debug_serial_pin_o ##1 debug_serial_pin_oe_n_o;
  endsequence

  property p_rx_quiet;
    (state_reg == ST_BIT && !cur_tx_reg) |-> debug_serial_pin_oe_n_o;
  endproperty
  a_rx_quiet: assert property (p_rx_quiet) else $error("Pin driven during host bit");

  property p_sample;
    (state_reg == ST_BIT && !cur_tx_reg && tick && to_reg != 10'h1FF &&
     cnt_reg == 8'h09) |=> ($changed(rx_cnt_reg) || rx_valid_o);
  endproperty
  a_sample: assert property (p_sample) else $error("Host bit not sampled at ten");

  property p_one_pulse;
    (state_reg == ST_BIT && cur_tx_reg && cur_bit_reg && tick && cnt_reg == 8'h06)
      |=> (!debug_serial_pin_oe_n_o && debug_serial_pin_o);
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("One pulse missing");

  property p_zero_low;
    (state_reg == ST_BIT && cur_tx_reg && !cur_bit_reg && cnt_reg < 8'h0D)
      |-> (!debug_serial_pin_oe_n_o && !debug_serial_pin_o);
  endproperty
  a_zero_low: assert property (p_zero_low) else $error("Zero bit not held low");

  property p_zero_pulse;
    (state_reg == ST_BIT && cur_tx_reg && !cur_bit_reg && cnt_reg == 8'h0D)
      |-> (!debug_serial_pin_oe_n_o && debug_serial_pin_o);
  endproperty
  a_zero_pulse: assert property (p_zero_pulse) else $error("Zero speedup missing");

  property p_timeout;
    (to_reg == 10'h1FF && tick && !pin.pin_fall) |=> (timeout_o && !tx_busy_o);
  endproperty
  a_timeout: assert property (p_timeout) else $error("Timeout did not abort");

  property p_sync_low;
    (state_reg == ST_SY_LOW) |-> (!debug_serial_pin_oe_n_o && !debug_serial_pin_o);
  endproperty
  a_sync_low: assert property (p_sync_low) else $error("Sync low not driven");

  property p_sync_end;
    (state_reg == ST_SY_PULSE && tick) |-> s_release;
  endproperty
  a_sync_end: assert property (p_sync_end) else $error("Sync pulse not released");

  property p_msb_first;
    (state_reg == ST_IDLE && pin.pin_fall && tx_busy_o && low_reg < 8'h3F)
      |=> (cur_bit_reg == $past(tx_sh_reg[TX_W-1]));
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("Not MSB first");

  property p_cmd_class;
    (cmd_active_class_i && !bgnd_mode_i) |-> !cmd_allowed_o;
  endproperty
  a_cmd_class: assert property (p_cmd_class) else $error("Active command allowed");

  property p_edge;
    pin.pin_fall |-> (!pin.pin_sync && $past(pin.pin_sync));
  endproperty
  a_edge: assert property (p_edge) else $error("Edge not from synced pin");
endmodule
`default_nettype wire

// >>> logic/sbdl_pin_if.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Debug pin path between the synchroniser and the link core
interface sbdl_pin_if;
  logic pin_raw;
  logic pin_sync;
  logic pin_fall;
  modport sync (input pin_raw, output pin_sync, output pin_fall);
  modport core (output pin_raw, input pin_sync, input pin_fall);
endinterface
`default_nettype wire

// >>> logic/sbdl_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Two-stage synchroniser and falling-edge detector
module sbdl_pin_sync (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Pin path
  sbdl_pin_if.sync pin
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;
  logic prev_reg;
  logic prev_next;

  // The first stage feeds only the second stage
  always_comb
  begin
    meta_next = pin.pin_raw;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_reg <= sbdl_pkg::SYNC_RST_LVL;
      sync_reg <= sbdl_pkg::SYNC_RST_LVL;
      prev_reg <= sbdl_pkg::SYNC_RST_LVL;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  assign pin.pin_sync = sync_reg;
  assign pin.pin_fall = prev_reg & ~sync_reg;
endmodule
`default_nettype wire

// >>> logic/sbdl_pkg.sv
`default_nettype none
// ==========================================================
// Shared constants of the single-wire debug bit link
package sbdl_pkg;
  // Cycle counts are in debug clock cycles, except BOOT_SETTLE_CYC in sys_clk_i cycles
  localparam int unsigned BIT_CYC = 16;
  localparam int unsigned SAMPLE_CYC = 10;
  localparam int unsigned ONE_PULSE_CYC = 7;
  localparam int unsigned ZERO_LOW_CYC = 13;
  localparam int unsigned TIMEOUT_CYC = 512;
  localparam int unsigned SYNC_DET_CYC = 64;
  localparam int unsigned SYNC_WAIT_CYC = 16;
  localparam int unsigned SYNC_LOW_CYC = 128;
  localparam int unsigned DELAY_CYC = 16;
  localparam int unsigned BOOT_SETTLE_CYC = 3;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned TO_W = 10;
  localparam int unsigned DLY_W = 5;
  localparam int unsigned BOOT_W = 2;
  localparam logic SYNC_RST_LVL = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_BIT,
    ST_SY_HIGH,
    ST_SY_DLY,
    ST_SY_LOW,
    ST_SY_PULSE
  } sbdl_state_e;
endpackage
`default_nettype wire

// >>> testbench/sbdl_host.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Debug pod model: opens every bit with its own falling edge
module sbdl_host (
  // Clock
  input wire logic sys_clk_i,
  // Wire level and device drive
  input wire logic pin_i,
  input wire logic dev_oe_n_i,
  input wire logic dev_pin_i,
  // Pod drive
  output var logic host_en_o,
  output var logic host_lvl_o
);
  int k = 1;
  logic tx_active = 1'b0;

  initial
  begin
    host_en_o = 1'b0;
    host_lvl_o = 1'b0;
  end

  task automatic drive(input logic en);
    host_en_o = en;
    host_lvl_o = 1'b0;
  endtask

  // Pod to device; level driven actively, not left to the pullup
  task automatic send_bit(input logic b);
    @(negedge sys_clk_i);
    tx_active = 1'b1;
    drive(1'b1);
    repeat (4*k) @(negedge sys_clk_i);
    host_lvl_o = b;
    repeat (10*k) @(negedge sys_clk_i);
    host_lvl_o = 1'b1;
    repeat (2*k) @(negedge sys_clk_i);
    host_en_o = 1'b0;
    tx_active = 1'b0;
    repeat (2*k) @(negedge sys_clk_i);
  endtask

  // Device to pod; counts the device's low and high drive cycles
  task automatic recv_bit(output logic b, output int lo, output int hi);
    lo = 0;
    hi = 0;
    @(negedge sys_clk_i);
    drive(1'b1);
    // Count from the first edge after ours, so a slow tick loses no drive cycle
    for (int i = 1; i < 18*k; i++)
    begin
      @(negedge sys_clk_i);
      if (i == 2*k)
        host_en_o = 1'b0;
      if (i == 10*k)
        b = pin_i;
      if (dev_oe_n_i === 1'b0)
      begin
        lo += int'(!dev_pin_i);
        hi += int'(dev_pin_i);
      end
    end
    @(negedge sys_clk_i);
  endtask

  // Rate probe: long low, speedup pulse, release, time the answer
  task automatic sync_req(output int lo);
    lo = 0;
    @(negedge sys_clk_i);
    drive(1'b1);
    repeat (200) @(negedge sys_clk_i);
    host_lvl_o = 1'b1;
    @(negedge sys_clk_i);
    host_en_o = 1'b0;
    for (int i = 0; i < 400; i++)
    begin
      @(negedge sys_clk_i);
      lo += int'(!pin_i);
    end
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic clk_sel = 1'b0;
  logic alt_tick = 1'b0;
  logic tx_load = 1'b0;
  logic [15:0] tx_data = 16'h0000;
  logic [4:0] tx_bits = 5'h00;
  logic bgnd_mode = 1'b0;
  logic cls = 1'b0;
  logic dly_req = 1'b0;
  logic pin_o, oe_n, host_en, host_lvl, tx_busy, rx_valid, allowed;
  logic dly_done, tmo, bstart, sbusy;
  logic [7:0] rx_data;
  logic [7:0] rx_q[$];
  wire pin;
  int miscompares = 0;
  int n_tests = 0;
  int seed = 84531;
  int n_to = 0;
  int n_drv = 0;

  // ==========================================================
  // Wire with pullup: any low drive wins
  assign pin = (oe_n ? 1'b1 : pin_o) & (host_en ? host_lvl : 1'b1);

  always #20 sys_clk_i = ~sys_clk_i;
  always @(negedge sys_clk_i) alt_tick <= ~alt_tick;

  sbdl_link i_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .debug_serial_pin_i(pin),
    .debug_serial_pin_o(pin_o), .debug_serial_pin_oe_n_o(oe_n),
    .debug_clock_select_i(clk_sel), .alt_clk_tick_i(alt_tick),
    .tx_load_i(tx_load), .tx_data_i(tx_data), .tx_bits_i(tx_bits), .tx_busy_o(tx_busy),
    .rx_data_o(rx_data), .rx_valid_o(rx_valid), .bgnd_mode_i(bgnd_mode),
    .cmd_active_class_i(cls), .cmd_allowed_o(allowed), .delay_req_i(dly_req),
    .delay_done_o(dly_done), .timeout_o(tmo), .bgnd_start_o(bstart), .sync_busy_o(sbusy)
  );

  sbdl_host i_host (
    .sys_clk_i(sys_clk_i), .pin_i(pin), .dev_oe_n_i(oe_n), .dev_pin_i(pin_o),
    .host_en_o(host_en), .host_lvl_o(host_lvl)
  );

  always @(posedge sys_clk_i)
  begin
    if (tmo === 1'b1)
      n_to++;
    if (i_host.tx_active && oe_n !== 1'b1)
      n_drv++;
    if (rx_valid === 1'b1)
      rx_q.push_back(rx_data);
  end

  // ==========================================================
  // Checking and closing
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #(40 * 40000);
    miscompares++;
    stop_test();
  end

  // ==========================================================
  // Scenario tasks
  task automatic do_reset(input logic low);
    @(negedge sys_clk_i);
    i_host.drive(low);
    rst_n_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    check("start mode", 16'(bstart), 16'(low));
    i_host.drive(1'b0);
    // Long idle lets the timeout drop the stray bit from the release
    repeat (600) @(negedge sys_clk_i);
    $display("test reset done");
  endtask

  task automatic rx_bytes(input int n);
    logic [7:0] v;
    logic [7:0] exp_q[$];
    rx_q.delete();
    n_drv = 0;
    for (int j = 0; j < n; j++)
    begin
      v = 8'($random(seed));
      exp_q.push_back(v);
      for (int i = 7; i >= 0; i--)
        i_host.send_bit(v[i]);
    end
    repeat (4) @(negedge sys_clk_i);
    check("rx count", 16'(rx_q.size()), 16'(exp_q.size()));
    foreach (exp_q[j])
      check("rx byte", 16'(rx_q[j]), 16'(exp_q[j]));
    check("drive while receiving", 16'(n_drv), 16'h0000);
    $display("test receive done");
  endtask

  task automatic tx_word(input logic [15:0] d, input logic [4:0] n);
    logic b;
    int lo;
    int hi;
    int k;
    k = i_host.k;
    @(negedge sys_clk_i);
    tx_data = d;
    tx_bits = n;
    tx_load = 1'b1;
    @(negedge sys_clk_i);
    tx_load = 1'b0;
    check("busy", 16'(tx_busy), 16'h0001);
    for (int i = 0; i < n; i++)
    begin
      i_host.recv_bit(b, lo, hi);
      check("tx bit", 16'(b), 16'(d[15-i]));
      if (d[15-i])
        check("one low", 16'(lo), 16'h0000);
      else
        check("zero low", 16'((lo - 12*k - 1) inside {[0:k-1]}), 16'h0001);
      check("pulse", 16'((hi - 1) inside {[0:2*k-2]}), 16'h0001);
    end
    check("busy", 16'(tx_busy), 16'h0000);
    $display("test transmit done");
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    int lo;
    int n;
    logic b;
    do_reset(1'b1);
    do_reset(1'b0);
    for (int i = 0; i < 4; i++)
    begin
      @(negedge sys_clk_i);
      {bgnd_mode, cls} = 2'(i);
      #1;
      check("allowed", 16'(allowed), 16'(!cls || bgnd_mode));
    end
    $display("test command class done");
    bgnd_mode = 1'b0;
    rx_bytes(4);
    tx_word(16'($random(seed)), 5'h10);
    tx_word(16'($random(seed)), 5'(($random(seed) & 15) + 1));
    i_host.recv_bit(b, lo, n);
    check("idle drive", 16'(lo + n), 16'h0000);
    // Abort in mid-word, then a clean byte must still arrive
    @(negedge sys_clk_i);
    tx_data = 16'hA5C3;
    tx_bits = 5'h08;
    tx_load = 1'b1;
    @(negedge sys_clk_i);
    tx_load = 1'b0;
    i_host.recv_bit(b, lo, n);
    i_host.recv_bit(b, lo, n);
    n_to = 0;
    repeat (600) @(negedge sys_clk_i);
    check("timeouts", 16'(n_to), 16'h0001);
    check("busy after timeout", 16'(tx_busy), 16'h0000);
    rx_bytes(1);
    @(negedge sys_clk_i);
    dly_req = 1'b1;
    @(negedge sys_clk_i);
    dly_req = 1'b0;
    n = 1;
    while (dly_done !== 1'b1 && n < 40)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    check("delay slot", 16'((n - 16) inside {[0:1]}), 16'h0001);
    i_host.sync_req(lo);
    check("probe low", 16'(lo), 16'h0080);
    check("probe busy", 16'(sbusy), 16'h0000);
    $display("test rate probe done");
    clk_sel = 1'b1;
    i_host.k = 2;
    tx_word(16'h4000, 5'h02);
    stop_test();
  end
endmodule
`default_nettype wire
